// ===== rtl/stp_pkg.sv
// Package for the serial-to-network packetizer: register layouts, timing, states.
// Assumes one 250 MHz clock; configuration arrives as plain register ports.
// Operation
// - Policy bit 7 set: drop connection when modem status falls high to low.
// - Policy bit 7 clear: modem status never affects the connection.
// - Policy bit 6 set: remote port control on, send terminal type outbound.
// - Policy bit 4 set: network connections need a correct port password.
// - Bit 3 clear: force close without acknowledge; set disables forced close.
// - Policy bit 0 set: state indicator held off while connected.
// - Bits 5 and 6 set: serial byte 0x04 toward network drops connection.
// - On disconnect clear serial-side buffer if bit 6, network-side if bit 2.
// - Clear network-to-serial buffer on own outgoing connect if bit 0.
// - Clear network-to-serial buffer on accepted incoming connect if bit 1.
// - Buffer policy bit 7 selects alternate packing under packing control.
// - Interval code 00/01/10/11 gives 12 ms, 52 ms, 250 ms, 5 s.
// - Alternate packing defaults to the 12 ms interval.
// - Trailing field adds zero, one, two or three characters after a match.
// - Sequence option: trigger only on first then second match character.
// - Send-immediately sends at trigger; else buffered characters join it.
// - A match character is sent at once with all waiting characters.
// - First match character zero disables match recognition.
// - Serial inactivity for the set seconds drops connection; zero disables.
// - Auto-increment gives each new outgoing connection a new source port.
// - Modem mode ring message carries caller address when option on.
// - Escape option, default on, enables plus-plus-plus handling.
// - Ring message names the remote caller with dotted address.
package stp_pkg;
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned INTERVAL_12_US  = 12_000;
  localparam int unsigned INTERVAL_52_US  = 52_000;
  localparam int unsigned INTERVAL_250_US = 250_000;
  localparam int unsigned INTERVAL_5S_US  = 5_000_000;
  localparam int unsigned SECOND_US       = 1_000_000;
  localparam int unsigned FIFO_DEPTH      = 4;
  localparam int unsigned FIFO_WIDTH      = 8;
  localparam logic [7:0]  EOT_CHAR        = 8'h04;
  localparam logic [7:0]  PLUS_CHAR       = 8'h2B;
  localparam logic [7:0]  ZERO_CHAR       = 8'h00;
  localparam logic [12:0] TIMEOUT_MAX     = 13'h176F;
  // disconnect_policy bit positions
  localparam int unsigned DP_MODEM   = 7;
  localparam int unsigned DP_TELNET  = 6;
  localparam int unsigned DP_EOT     = 5;
  localparam int unsigned DP_PASS    = 4;
  localparam int unsigned DP_NOHARD  = 3;
  localparam int unsigned DP_LEDOFF  = 0;
  // buffer_clear_policy bit positions
  localparam int unsigned BP_ALT     = 7;
  localparam int unsigned BP_S2N_DIS = 6;
  localparam int unsigned BP_N2S_DIS = 2;
  localparam int unsigned BP_N2S_IN  = 1;
  localparam int unsigned BP_N2S_OUT = 0;
  // packing_control fields
  localparam int unsigned PC_IVL_LSB   = 6;
  localparam int unsigned PC_TRAIL_LSB = 3;
  localparam int unsigned PC_SEQ       = 1;
  localparam int unsigned PC_IMM       = 0;
  localparam logic [7:0] DISCONNECT_POLICY_RST = 8'h00;
  localparam logic [7:0] BUFFER_POLICY_RST     = 8'h00;
  localparam logic [7:0] PACKING_CONTROL_RST   = 8'h00;
  localparam logic [15:0] SRC_PORT_BASE        = 16'h2710;

  typedef enum logic [1:0] {
    STP_IDLE = 2'b00,
    STP_COLLECT = 2'b01,
    STP_TRAIL = 2'b10,
    STP_SEND = 2'b11
  } stp_pack_e;

  typedef struct packed {
    logic [7:0] disconnect_policy;
    logic [7:0] buffer_clear_policy;
    logic [7:0] packing_control;
    logic [7:0] match_char1;
    logic [7:0] match_char2;
    logic [12:0] inactivity_timeout;
    logic auto_increment;
    logic show_ring_ip;
    logic escape_enable;
  } stp_cfg_s;

  typedef struct packed {
    logic drop_req;
    logic hard_close;
    logic clear_s2n;
    logic clear_n2s;
  } stp_ctl_s;
endpackage

// ===== rtl/stp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; flush empties it in one cycle.
`timescale 1ns/10ps
module stp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_sys,   // System clock
  input  wire logic             arst_n,    // Async reset, active low
  input  wire logic             flush,     // Drop all contents
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  input  wire logic             in_valid,  // Write offered
  output logic                  in_ready,  // Space available
  output logic      [WIDTH-1:0] out_data,  // Head word
  output logic                  out_valid, // Head present
  input  wire logic             out_ready, // Head taken
  output logic [$clog2(DEPTH):0] level     // Words held
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              do_wr = in_valid && in_ready;
  wire              do_rd = out_valid && out_ready;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign level     = count;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + AW'(1);
      if (do_rd) rd_ptr <= rd_ptr + AW'(1);
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ===== rtl/stp_packetizer.sv
// Serial-to-network channel policy: packing, match triggers, buffer clears, drops.
// Assumes serial bytes and network events arrive on clk_sys; modem status is a pin.
`timescale 1ns/10ps
module stp_packetizer #(
  parameter int unsigned SECOND_CYCLES = stp_pkg::SECOND_US * (stp_pkg::CLK_HZ / 1_000_000)
) (
  input  wire logic             clk_sys,            // System clock 250 MHz
  input  wire logic             arst_n,             // Async reset, active low
  input  wire stp_pkg::stp_cfg_s cfg,               // Configuration registers
  input  wire logic             modem_status,       // Modem control in pin
  input  wire logic             connected,          // Network connection open
  input  wire logic             conn_out_start,     // Pulse: device opens connection
  input  wire logic             conn_in_accept,     // Pulse: network connection accepted
  input  wire logic             conn_closed,        // Pulse: connection ended
  input  wire logic             password_ok,        // Peer gave correct port password
  input  wire logic [7:0]       ser_data,           // Serial byte received
  input  wire logic             ser_valid,          // Serial byte offered
  output logic                  ser_ready,          // Serial byte accepted
  output logic [7:0]            net_data,           // Segment byte
  output logic                  net_valid,          // Segment byte offered
  output logic                  net_last,           // Last byte of segment
  input  wire logic             net_ready,          // Network takes byte
  output stp_pkg::stp_ctl_s     ctl,                // Drop and clear commands
  output logic                  accept_allowed,     // Incoming connect may proceed
  output logic                  telnet_ctl_en,      // Remote port control enabled
  output logic                  send_term_type,     // Pulse: send terminal type
  output logic                  state_led,          // State indicator on
  output logic [15:0]           src_port,           // Local source port
  output logic                  ring_show_ip,       // Put caller address in ring
  output logic                  escape_en,          // Escape sequence handling on
  output logic                  escape_detect       // Pulse: valid escape seen
);
  localparam int unsigned C12  = stp_pkg::INTERVAL_12_US * (stp_pkg::CLK_HZ / 1_000_000);
  localparam int unsigned C52  = stp_pkg::INTERVAL_52_US * (stp_pkg::CLK_HZ / 1_000_000);
  localparam int unsigned C250 = stp_pkg::INTERVAL_250_US * (stp_pkg::CLK_HZ / 1_000_000);
  localparam int unsigned C5S  = stp_pkg::INTERVAL_5S_US * (stp_pkg::CLK_HZ / 1_000_000);

  logic [7:0] dp;
  logic [7:0] bp;
  logic [7:0] pc;
  assign dp = cfg.disconnect_policy;
  assign bp = cfg.buffer_clear_policy;
  assign pc = cfg.packing_control;

  // Modem status pin synchroniser
  logic ms_s1;
  logic ms_s2;
  logic ms_d;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ms_s1 <= 1'b0;
      ms_s2 <= 1'b0;
      ms_d  <= 1'b0;
    end else begin
      ms_s1 <= modem_status;
      ms_s2 <= ms_s1;
      ms_d  <= ms_s2;
    end
  end
  wire modem_fall = ms_d && !ms_s2;
  wire modem_drop = dp[stp_pkg::DP_MODEM] && modem_fall && connected;

  // Serial intake into FIFO
  logic [7:0] f_dout;
  logic       f_ovalid;
  logic       f_oready;
  logic       f_iready;
  logic [2:0] f_level;
  logic       s2n_flush;
  wire        ser_take = ser_valid && f_iready;
  assign ser_ready = f_iready;

  stp_fifo #(.WIDTH(stp_pkg::FIFO_WIDTH), .DEPTH(stp_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .flush     (s2n_flush),
    .in_data   (ser_data),
    .in_valid  (ser_valid),
    .in_ready  (f_iready),
    .out_data  (f_dout),
    .out_valid (f_ovalid),
    .out_ready (f_oready),
    .level     (f_level)
  );

  // Match detection on intake
  logic [7:0] prev_char;
  logic       prev_valid;
  wire match_on  = (cfg.match_char1 != stp_pkg::ZERO_CHAR);
  wire seq_mode  = pc[stp_pkg::PC_SEQ];
  wire hit_seq   = prev_valid && (prev_char == cfg.match_char1) && (ser_data == cfg.match_char2);
  wire hit_any   = (ser_data == cfg.match_char1) || (ser_data == cfg.match_char2);
  wire match_hit = ser_take && match_on && (seq_mode ? hit_seq : hit_any);
  wire eot_drop  = ser_take && connected && dp[stp_pkg::DP_EOT] && dp[stp_pkg::DP_TELNET]
                   && (ser_data == stp_pkg::EOT_CHAR);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_char  <= 8'h00;
      prev_valid <= 1'b0;
    end else if (ser_take) begin
      prev_char  <= ser_data;
      prev_valid <= 1'b1;
    end
  end

  // Packing interval selection
  wire       alt_pack = bp[stp_pkg::BP_ALT];
  wire [1:0] ivl_code = alt_pack ? pc[stp_pkg::PC_IVL_LSB +: 2] : 2'b00;
  logic [31:0] ivl_cycles;
  always_comb begin
    case (ivl_code)
      2'b00:   ivl_cycles = C12;
      2'b01:   ivl_cycles = C52;
      2'b10:   ivl_cycles = C250;
      default: ivl_cycles = C5S;
    endcase
  end
  wire [1:0] trail_cfg = alt_pack ? pc[stp_pkg::PC_TRAIL_LSB +: 2] : 2'b00;
  wire       send_imm  = alt_pack && pc[stp_pkg::PC_IMM];

  // Segment former: counts bytes owed to the current segment
  stp_pkg::stp_pack_e state;
  stp_pkg::stp_pack_e next_state;
  logic [31:0] ivl_cnt;
  logic [1:0]  trail_left;
  logic [2:0]  seg_len;
  logic        ivl_done;
  assign ivl_done = (ivl_cnt >= ivl_cycles - 32'd1);

  always_comb begin
    next_state = state;
    case (state)
      stp_pkg::STP_IDLE: begin
        if (match_hit && trail_cfg != 2'b00) next_state = stp_pkg::STP_TRAIL;
        else if (match_hit) next_state = stp_pkg::STP_SEND;
        else if (ser_take) next_state = stp_pkg::STP_COLLECT;
      end
      stp_pkg::STP_COLLECT: begin
        if (match_hit && trail_cfg != 2'b00) next_state = stp_pkg::STP_TRAIL;
        else if (match_hit || (ivl_done && f_ovalid)) next_state = stp_pkg::STP_SEND;
      end
      stp_pkg::STP_TRAIL:   if ((ser_take && trail_left == 2'd1) || ivl_done) next_state = stp_pkg::STP_SEND;
      // An empty buffer also ends the segment, so a short one never waits for bytes
      stp_pkg::STP_SEND:
        if (seg_len == 3'd0 || !f_ovalid || (f_oready && seg_len == 3'd1)) next_state = stp_pkg::STP_IDLE;
      default:              next_state = stp_pkg::STP_IDLE;
    endcase
  end

  // Segment length fixed at trigger; without send-immediately, later buffered bytes join.
  wire       entering_send = (next_state == stp_pkg::STP_SEND) && (state != stp_pkg::STP_SEND);
  wire [2:0] snap_len      = f_level + 3'(ser_take);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state      <= stp_pkg::STP_IDLE;
      ivl_cnt    <= 32'd0;
      trail_left <= 2'd0;
      seg_len    <= 3'd0;
    end else if (s2n_flush) begin
      state      <= stp_pkg::STP_IDLE;
      ivl_cnt    <= 32'd0;
      trail_left <= 2'd0;
      seg_len    <= 3'd0;
    end else begin
      state <= next_state;
      if (ser_take || state == stp_pkg::STP_IDLE) ivl_cnt <= 32'd0;
      else if (!ivl_done) ivl_cnt <= ivl_cnt + 32'd1;
      if (next_state == stp_pkg::STP_TRAIL && state != stp_pkg::STP_TRAIL) trail_left <= trail_cfg;
      else if (state == stp_pkg::STP_TRAIL && ser_take) trail_left <= trail_left - 2'd1;
      if (entering_send) seg_len <= send_imm ? snap_len : 3'(stp_pkg::FIFO_DEPTH);
      else if (f_oready && seg_len != 3'd0) seg_len <= seg_len - 3'd1;
    end
  end

  wire sending = (state == stp_pkg::STP_SEND) && (seg_len != 3'd0);
  assign f_oready  = sending && net_ready;
  assign net_valid = sending && f_ovalid;
  assign net_data  = f_dout;
  assign net_last  = sending && (seg_len == 3'd1 || f_level == 3'd1);

  // Inactivity timeout in seconds
  logic [31:0] sec_cnt;
  logic [12:0] idle_sec;
  wire to_on   = (cfg.inactivity_timeout != 13'd0);
  wire to_hit  = to_on && connected && (idle_sec >= cfg.inactivity_timeout);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sec_cnt  <= 32'd0;
      idle_sec <= 13'd0;
    end else if (ser_take || !connected) begin
      sec_cnt  <= 32'd0;
      idle_sec <= 13'd0;
    end else if (sec_cnt == SECOND_CYCLES - 1) begin
      sec_cnt <= 32'd0;
      if (idle_sec != stp_pkg::TIMEOUT_MAX) idle_sec <= idle_sec + 13'd1;
    end else begin
      sec_cnt <= sec_cnt + 32'd1;
    end
  end

  // Escape: one second silence, three pluses, one second silence
  logic [1:0] plus_cnt;
  logic       guard_ok;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      plus_cnt      <= 2'd0;
      guard_ok      <= 1'b0;
      escape_detect <= 1'b0;
    end else begin
      escape_detect <= 1'b0;
      if (!cfg.escape_enable || !connected) begin
        plus_cnt <= 2'd0;
      end else if (ser_take) begin
        if (ser_data == stp_pkg::PLUS_CHAR && (guard_ok || plus_cnt != 2'd0) && plus_cnt != 2'd3)
          plus_cnt <= plus_cnt + 2'd1;
        else
          plus_cnt <= 2'd0;
      end else if (sec_cnt == SECOND_CYCLES - 1) begin
        if (plus_cnt == 2'd3) escape_detect <= 1'b1;
        plus_cnt <= 2'd0;
      end
      guard_ok <= !ser_take && (sec_cnt == SECOND_CYCLES - 1 || (guard_ok && !ser_take));
    end
  end

  // Connection control and buffer clears
  wire drop_any = modem_drop || eot_drop || to_hit;
  assign s2n_flush = conn_closed && bp[stp_pkg::BP_S2N_DIS];
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctl            <= '0;
      send_term_type <= 1'b0;
      src_port       <= stp_pkg::SRC_PORT_BASE;
    end else begin
      ctl.drop_req   <= drop_any;
      ctl.hard_close <= drop_any && !dp[stp_pkg::DP_NOHARD];
      ctl.clear_s2n  <= s2n_flush;
      ctl.clear_n2s  <= (conn_closed && bp[stp_pkg::BP_N2S_DIS])
                      || (conn_out_start && bp[stp_pkg::BP_N2S_OUT])
                      || (conn_in_accept && bp[stp_pkg::BP_N2S_IN]);
      send_term_type <= conn_out_start && dp[stp_pkg::DP_TELNET];
      if (conn_out_start && cfg.auto_increment) src_port <= src_port + 16'd1;
    end
  end

  // Indicator blink toggles at each second counter wrap, and every cycle while disconnected
  logic blink;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) blink <= 1'b0;
    else if (sec_cnt == SECOND_CYCLES - 1 || (!connected && sec_cnt == 32'd0)) blink <= ~blink;
  end
  assign state_led      = (connected && dp[stp_pkg::DP_LEDOFF]) ? 1'b0 : blink;
  assign accept_allowed = !dp[stp_pkg::DP_PASS] || password_ok;
  assign telnet_ctl_en  = dp[stp_pkg::DP_TELNET];
  assign ring_show_ip   = cfg.show_ring_ip;
  assign escape_en      = cfg.escape_enable;
endmodule

// ===== testbench/stp_packetizer_properties.sv
// Port checks for the packetizer.
// Assumes one clock domain; bound to stp_packetizer.
`timescale 1ns/10ps
module stp_packetizer_properties (
  input wire logic              clk_sys,        // Clock
  input wire logic              arst_n,         // Reset
  input wire stp_pkg::stp_cfg_s cfg,            // Config
  input wire logic              modem_status,   // Modem pin
  input wire logic              connected,      // Link up
  input wire logic              conn_out_start, // Outgoing
  input wire logic              conn_in_accept, // Incoming
  input wire logic              conn_closed,    // Closed
  input wire logic              password_ok,    // Password
  input wire logic [7:0]        ser_data,       // Byte
  input wire logic              ser_valid,      // Offered
  input wire logic              ser_ready,      // Taken
  input wire logic              net_valid,      // Out byte
  input wire stp_pkg::stp_ctl_s ctl,            // Commands
  input wire logic              accept_allowed, // Accept
  input wire logic              telnet_ctl_en,  // Port ctl
  input wire logic              send_term_type, // Term type
  input wire logic              state_led,      // LED
  input wire logic [15:0]       src_port        // Port
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic [7:0] dp = cfg.disconnect_policy;
  wire logic [7:0] bp = cfg.buffer_clear_policy;
  sequence s_taken(logic [7:0] b);
    ser_valid && ser_ready && ser_data == b;
  endsequence
  a_modem_drop: assert property (dp[7] && connected && $fell(modem_status) |-> ##[1:4] ctl.drop_req)
    else $error("modem fall not dropped");
  a_modem_ignored: assert property (!dp[7] && !dp[5] && $fell(modem_status) && !ser_valid
    && cfg.inactivity_timeout == 13'h0000 |=> !ctl.drop_req [*4]) else $error("modem fall dropped");
  a_eot_drop: assert property ((dp[5] && dp[6] && connected) ##0 s_taken(stp_pkg::EOT_CHAR) |=> ctl.drop_req)
    else $error("eot not dropped");
  a_hard_close: assert property (ctl.drop_req |-> ctl.hard_close == !$past(dp[3]))
    else $error("hard close wrong");
  a_clear_out: assert property (conn_out_start && bp[0] |=> ctl.clear_n2s)
    else $error("no clear on outgoing");
  a_clear_in: assert property (conn_in_accept && bp[1] |=> ctl.clear_n2s)
    else $error("no clear on incoming");
  a_clear_s2n: assert property (conn_closed && bp[6] |=> ctl.clear_s2n)
    else $error("no s2n clear");
  a_clear_n2s: assert property (conn_closed && bp[2] |=> ctl.clear_n2s)
    else $error("no n2s clear");
  a_led_off: assert property (connected && dp[0] |-> !state_led)
    else $error("led on");
  a_port_password: assert property (accept_allowed == (!dp[4] || password_ok))
    else $error("accept wrong");
  a_telnet_enable: assert property (telnet_ctl_en == dp[6])
    else $error("telnet enable wrong");
  a_term_type: assert property (conn_out_start && dp[6] |=> send_term_type)
    else $error("no terminal type");
  a_port_incr: assert property (conn_out_start && cfg.auto_increment |=> src_port == $past(src_port) + 16'h0001)
    else $error("port not incremented");
  a_match_send: assert property ((!bp[7] && cfg.packing_control[0] && cfg.match_char1 != 8'h00)
    ##0 s_taken(cfg.match_char1) |-> ##[1:3] net_valid) else $error("match not sent");
endmodule
bind stp_packetizer stp_packetizer_properties u_stp_packetizer_properties (
  .clk_sys(clk_sys), .arst_n(arst_n), .cfg(cfg), .modem_status(modem_status), .connected(connected),
  .conn_out_start(conn_out_start), .conn_in_accept(conn_in_accept), .conn_closed(conn_closed),
  .password_ok(password_ok), .ser_data(ser_data), .ser_valid(ser_valid), .ser_ready(ser_ready),
  .net_valid(net_valid), .ctl(ctl), .accept_allowed(accept_allowed), .telnet_ctl_en(telnet_ctl_en),
  .send_term_type(send_term_type), .state_led(state_led), .src_port(src_port));

// ===== testbench/stp_net_host.sv
// Network peer model: takes segment bytes, counts segments.
// Assumes one clock; stall makes it take one byte in four cycles.
`timescale 1ns/10ps
module stp_net_host (
  input  wire logic       clk_sys,   // Clock
  input  wire logic       arst_n,    // Reset
  input  wire logic [7:0] net_data,  // Byte
  input  wire logic       net_valid, // Offered
  input  wire logic       net_last,  // Segment end
  input  wire logic       stall,     // Slow peer
  output logic            net_ready, // Taken
  output logic [7:0]      seg_count  // Segments
);
  logic [7:0] rx_q[$];
  logic [1:0] phase;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'b00;
      seg_count <= 8'h00;
    end else begin
      phase <= phase + 2'b01;
      if (net_valid && net_ready) begin
        rx_q.push_back(net_data);
        if (net_last)
          seg_count <= seg_count + 8'h01;
      end
    end
  end
  // Ready decodes the stall input and the phase register, so it moves when either changes
  assign net_ready = !stall || (phase == 2'b11);
endmodule

// ===== testbench/tb_stp_packetizer.sv
// Testbench for the packetizer with a network peer model.
// Assumes a one-second count shortened to 1000 cycles.
`timescale 1ns/10ps
module tb_stp_packetizer;
  logic              clk_sys, arst_n, modem_status, connected, conn_out_start, conn_in_accept, conn_closed;
  logic              password_ok, ser_valid, ser_ready, net_valid, net_last, net_ready, stall;
  logic              accept_allowed, telnet_ctl_en, send_term_type, state_led, ring_show_ip, escape_en, escape_detect;
  logic [7:0]        ser_data, net_data, seg_count;
  logic [15:0]       src_port;
  stp_pkg::stp_cfg_s cfg;
  stp_pkg::stp_ctl_s ctl;
  int                fail_count, num_checks, n;

  stp_packetizer #(.SECOND_CYCLES(1000)) u_stp_packetizer (.clk_sys(clk_sys), .arst_n(arst_n), .cfg(cfg),
    .modem_status(modem_status), .connected(connected), .conn_out_start(conn_out_start),
    .conn_in_accept(conn_in_accept), .conn_closed(conn_closed), .password_ok(password_ok),
    .ser_data(ser_data), .ser_valid(ser_valid), .ser_ready(ser_ready), .net_data(net_data),
    .net_valid(net_valid), .net_last(net_last), .net_ready(net_ready), .ctl(ctl),
    .accept_allowed(accept_allowed), .telnet_ctl_en(telnet_ctl_en), .send_term_type(send_term_type),
    .state_led(state_led), .src_port(src_port), .ring_show_ip(ring_show_ip), .escape_en(escape_en),
    .escape_detect(escape_detect));
  stp_net_host u_stp_net_host (.clk_sys(clk_sys), .arst_n(arst_n), .net_data(net_data),
    .net_valid(net_valid), .net_last(net_last), .stall(stall), .net_ready(net_ready), .seg_count(seg_count));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    tick(16);
    arst_n = 1'b1;
    u_stp_net_host.rx_q.delete();
    tick(1);
  endtask
  // Valid stays up between bytes so it is never lowered and raised in one step
  task automatic send(input logic [7:0] b, input bit last);
    ser_data = b;
    ser_valid = 1'b1;
    for (int i = 0; i < 50 && ser_ready !== 1'b1; i++)
      tick(1);
    tick(1);
    if (last)
      ser_valid = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wait_drop(input int lim, output int c);
    c = 0;
    while (ctl.drop_req !== 1'b1 && c < lim) begin
      tick(1);
      c++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    test_done();
  end

  initial begin
    arst_n = 1'b0;
    cfg = '0;
    {modem_status, connected, conn_out_start, conn_in_accept, conn_closed} = 5'b10000;
    {password_ok, ser_valid, stall, ser_data} = 11'h000;
    do_reset();
    check(src_port, 16'h2710);
    check({ser_ready, net_valid, ctl}, 16'h0020);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      cfg.disconnect_policy = {1'b0, i[0], 1'b0, i[1], 4'b0000};
      password_ok = i[0];
      {cfg.show_ring_ip, cfg.escape_enable} = {i[1], i[0]};
      tick(1);
      check(telnet_ctl_en, i[0]);
      check(accept_allowed, !i[1] || i[0]);
      check({ring_show_ip, escape_en}, {i[1], i[0]});
    end
    $display("level test done");
    cfg = '0;
    cfg.match_char1 = 8'h0D;
    cfg.packing_control = 8'h01;
    connected = 1'b1;
    stall = 1'b1;
    send(8'h41, 0);
    send(8'h42, 0);
    send(8'h0D, 1);
    for (n = 0; n < 200 && seg_count == 8'h00; n++)
      tick(1);
    check(seg_count, 16'h0001);
    check(u_stp_net_host.rx_q.size(), 16'h0003);
    check(u_stp_net_host.rx_q[0], 16'h0041);
    check(u_stp_net_host.rx_q[2], 16'h000D);
    stall = 1'b0;
    $display("match test done");
    do_reset();
    cfg.match_char2 = 8'h0A;
    cfg.buffer_clear_policy = 8'h80;
    cfg.packing_control = 8'h0B;
    send(8'h0A, 0);
    send(8'h0D, 0);
    send(8'h0A, 0);
    send(8'h55, 1);
    tick(20);
    check(seg_count, 16'h0001);
    check(u_stp_net_host.rx_q.size(), 16'h0004);
    check(u_stp_net_host.rx_q[3], 16'h0055);
    $display("alternate packing test done");
    do_reset();
    cfg = '0;
    cfg.match_char2 = 8'h0D;
    cfg.buffer_clear_policy = 8'h44;
    for (int i = 0; i < 4; i++)
      send(8'h0D, i == 3);
    tick(50);
    check(ser_ready, 16'h0000);
    check(net_valid, 16'h0000);
    pulse(conn_closed);
    check({ctl.clear_s2n, ctl.clear_n2s}, 16'h0003);
    tick(1);
    check(ser_ready, 16'h0001);
    $display("buffer test done");
    do_reset();
    cfg.disconnect_policy = 8'hE0;
    tick(4);
    modem_status = 1'b0;
    wait_drop(8, n);
    check(n < 8, 16'h0001);
    check(ctl.hard_close, 16'h0001);
    modem_status = 1'b1;
    tick(4);
    cfg.disconnect_policy = 8'h68;
    send(stp_pkg::EOT_CHAR, 1);
    wait_drop(2, n);
    check(n < 2, 16'h0001);
    check(ctl.hard_close, 16'h0000);
    cfg.disconnect_policy = 8'h00;
    tick(4);
    modem_status = 1'b0;
    wait_drop(10, n);
    check(n, 16'h000A);
    $display("drop test done");
    do_reset();
    cfg.buffer_clear_policy = 8'h03;
    cfg.auto_increment = 1'b1;
    cfg.disconnect_policy = 8'h40;
    pulse(conn_out_start);
    check({ctl.clear_n2s, send_term_type}, 16'h0003);
    tick(1);
    check(src_port, 16'h2711);
    pulse(conn_in_accept);
    check(ctl.clear_n2s, 16'h0001);
    cfg.auto_increment = 1'b0;
    pulse(conn_out_start);
    tick(1);
    check(src_port, 16'h2711);
    $display("connect test done");
    cfg = '0;
    for (int k = 1; k >= 0; k--) begin
      cfg.disconnect_policy = {7'h00, k[0]};
      n = 0;
      repeat (2200) begin
        tick(1);
        if (state_led === 1'b1)
          n++;
      end
      check(n > 0, !k[0]);
    end
    $display("led test done");
    do_reset();
    cfg.escape_enable = 1'b1;
    tick(1010);
    for (int j = 0; j < 3; j++)
      send(stp_pkg::PLUS_CHAR, j == 2);
    for (n = 0; n < 1100 && escape_detect !== 1'b1; n++)
      tick(1);
    check(escape_detect, 16'h0001);
    $display("escape test done");
    do_reset();
    cfg.inactivity_timeout = 13'h0001;
    wait_drop(1500, n);
    check(n > 900 && n < 1100, 16'h0001);
    $display("inactivity test done");
    test_done();
  end
endmodule
